// >>> core/ipv_pkg.sv
package ipv_pkg;
  // register port offsets
  localparam logic [7:0] REG_PIN_CTRL = 8'h00;
  localparam logic [7:0] REG_PENDING  = 8'h01;
  localparam logic [7:0] REG_SEQ_STAT = 8'h02;
  // pin_irq_status_control field positions
  localparam int BIT_LEVEL_MODE = 0;
  localparam int BIT_INT_ENABLE = 1;
  localparam int BIT_FLAG_ACK   = 2;
  localparam int BIT_FLAG       = 3;
  localparam int BIT_PIN_ENABLE = 4;
  localparam int BIT_POLARITY   = 5;
  localparam int BIT_PULL_DIS   = 6;
  localparam logic [7:0] PIN_CTRL_RESET = 8'h00;
  // vector numbers and table
  localparam logic [4:0]  VEC_SWI      = 5'h01;
  localparam logic [4:0]  VEC_PIN      = 5'h02;
  localparam logic [4:0]  VEC_NONE     = 5'h1F;
  localparam logic [15:0] VEC_TOP_ADDR = 16'hFFFE;
  // sources wired to vectors 29,26,25,21,20,19,11,10,9,7,5,4,3
  localparam logic [31:0] PERIPH_VALID = 32'h2638_0EB8;
  // stack frame and pipeline refill
  localparam logic [2:0] PUSH_BYTES = 3'h5;
  localparam logic [2:0] FILL_BYTES = 3'h3;
  localparam logic [7:0] SP_RESET   = 8'hFF;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PUSH = 3'b001,
    ST_VEC  = 3'b011,
    ST_FILL = 3'b010,
    ST_DONE = 3'b110,
    ST_POP  = 3'b100
  } ipv_state_e;
endpackage

// >>> core/ipv_irq_ctrl.sv
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// (RULE_01) entry pushes pc low, pc high, index low, accumulator, condition codes
// (RULE_02) stack writes start at stack pointer going down; ends one below ccr
// (RULE_03) pushed pc is the next instruction address had no interrupt come
// (RULE_04) return pops in reverse order, then fetches three bytes at restored pc
// (RULE_05) index high byte is never saved or restored automatically
// (RULE_06) pin requests only while pin function enable is 1
// (RULE_07) pin options: polarity, edge or edge plus level, interrupt or poll
// (RULE_08) pin sampled synchronously; async wake path while in stop mode
// (RULE_09) enabled pin with pull disable 0 gets pullup or pulldown per polarity
// (RULE_10) enabling pin sets its flag; software clears before enabling interrupt
// (RULE_11) software waits six cycles after clear in falling level 5V setup
// (RULE_12) level mode: flag set on assertion, uncleared while pin stays asserted
// (RULE_13) vector high byte at lower address, low byte at next address
// (RULE_14) source flag sets on event; request forwarded only if enable is 1
// (RULE_15) unmasked request: finish insn, stack, set mask, fetch top vector
// (RULE_16) lower vector number means higher priority; 0 highest, 31 lowest
// (RULE_17) fixed peripheral vector assignment from 29 down to 3
// (RULE_18) unassigned vectors carry no source
// (RULE_19) vector 2 pin, vector 1 software interrupt, vector 0 reset
// (RULE_20) polarity 0 falling or low, 1 rising or high; rising gives pulldown
//////////////////////////////////////////////////////////////////////////////
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module ipv_irq_ctrl
  import ipv_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // register port
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [7:0]  o_reg_rdata,
  // external pin
  input  wire logic        i_pin,
  input  wire logic        i_stop_mode,
  output logic             o_stop_wake,
  output logic             o_pull_up_en,
  output logic             o_pull_down_en,
  output logic             o_pin_level,
  // peripheral sources
  input  wire logic [31:0] i_periph_flag,
  input  wire logic [31:0] i_periph_enable,
  // core state
  input  wire logic        i_insn_boundary,
  input  wire logic        i_mask_bit,
  input  wire logic        i_swi_exec,
  input  wire logic        i_rti_exec,
  input  wire logic [15:0] i_next_pc,
  input  wire logic [7:0]  i_sp,
  input  wire logic [7:0]  i_acc,
  input  wire logic [7:0]  i_idx_low,
  input  wire logic [7:0]  i_ccr,
  // core memory port
  output logic      [15:0] o_mem_addr,
  output logic      [7:0]  o_mem_wdata,
  output logic             o_mem_wr,
  output logic             o_mem_rd,
  input  wire logic [7:0]  i_mem_rdata,
  // core results
  output logic             o_irq_req,
  output logic             o_busy,
  output logic             o_set_mask,
  output logic      [7:0]  o_fill_byte,
  output logic             o_fill_valid,
  output logic             o_done,
  output logic      [15:0] o_new_pc,
  output logic      [7:0]  o_new_sp,
  output logic      [7:0]  o_new_acc,
  output logic      [7:0]  o_new_idx_low,
  output logic      [7:0]  o_new_ccr
);

  // lowest set bit wins: vector 0 sits highest in memory and ranks first
  function automatic logic [4:0] pick_vector(input logic [31:0] pend);
    logic [4:0] v;
    v = VEC_NONE;
    for (int i = 31; i >= 0; i--) begin
      if (pend[i]) begin
        v = 5'(i); // [RULE_16]
      end
    end
    return v;
  endfunction

  function automatic logic [15:0] vector_addr(input logic [4:0] vec);
    return VEC_TOP_ADDR - {10'h000, vec, 1'b0}; // [RULE_13]
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin control register and detection
  logic [7:0] pin_ctrl_reg;
  logic       pin_flag_reg;
  logic       pin_prev_reg;
  logic       pin_smp_reg;
  logic       pin_en;
  logic       pin_asserted;
  logic       pin_edge;
  logic       ctrl_wr;
  logic       ack_wr;
  logic       en_rise;

  assign pin_en       = pin_ctrl_reg[BIT_PIN_ENABLE];
  assign pin_asserted = pin_ctrl_reg[BIT_POLARITY] ? pin_smp_reg : ~pin_smp_reg; // [RULE_20]
  assign pin_edge     = pin_en & pin_asserted & ~pin_prev_reg;
  assign ctrl_wr      = i_reg_wr && (i_reg_addr == REG_PIN_CTRL);
  assign ack_wr       = ctrl_wr & i_reg_wdata[BIT_FLAG_ACK];
  assign en_rise      = ctrl_wr & i_reg_wdata[BIT_PIN_ENABLE] & ~pin_en;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_ctrl_reg <= PIN_CTRL_RESET;
    end else if (ctrl_wr) begin
      pin_ctrl_reg <= i_reg_wdata & 8'h73; // [RULE_07]
    end
  end

  // one synchronous sample; the previous value feeds the edge detector
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_smp_reg  <= 1'b0;
      pin_prev_reg <= 1'b1;
    end else begin
      pin_smp_reg  <= i_pin; // [RULE_08]
      pin_prev_reg <= pin_asserted;
    end
  end

  // set beats ack; in level mode an asserted pin keeps the flag up
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_flag_reg <= 1'b0;
    end else if (en_rise) begin
      pin_flag_reg <= 1'b1; // [RULE_10]
    end else if (pin_edge) begin
      pin_flag_reg <= 1'b1; // [RULE_06]
    end else if (pin_en & pin_ctrl_reg[BIT_LEVEL_MODE] & pin_asserted) begin
      pin_flag_reg <= 1'b1; // [RULE_12]
    end else if (ack_wr) begin
      pin_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pull_up_en   <= 1'b0;
      o_pull_down_en <= 1'b0;
      o_pin_level    <= 1'b0;
    end else begin
      o_pull_up_en   <= pin_en & ~pin_ctrl_reg[BIT_PULL_DIS] & ~pin_ctrl_reg[BIT_POLARITY]; // [RULE_09]
      o_pull_down_en <= pin_en & ~pin_ctrl_reg[BIT_PULL_DIS] & pin_ctrl_reg[BIT_POLARITY]; // [RULE_09]
      o_pin_level    <= pin_smp_reg;
    end
  end

  // clocks are stopped in stop mode, so this path cannot wait for an edge
  assign o_stop_wake = i_stop_mode & pin_en &
                       (pin_ctrl_reg[BIT_POLARITY] ? i_pin : ~i_pin); // [RULE_08]

  //////////////////////////////////////////////////////////////////////////////
  // qualification and priority
  logic [31:0] pending;
  logic [4:0]  top_vec;
  logic        hw_req;

  always_comb begin
    pending          = i_periph_flag & i_periph_enable & PERIPH_VALID; // [RULE_14] [RULE_17] [RULE_18]
    pending[VEC_PIN] = pin_flag_reg & pin_en & pin_ctrl_reg[BIT_INT_ENABLE]; // [RULE_19]
    pending[VEC_SWI] = 1'b0;
    pending[0]       = 1'b0;
  end

  assign top_vec = pick_vector(pending);
  assign hw_req  = (pending != 32'h0000_0000) & ~i_mask_bit;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_irq_req <= 1'b0;
    end else begin
      o_irq_req <= hw_req; // [RULE_14]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // stacking, vector fetch, return and refill sequencer
  ipv_state_e  state_reg;
  logic [2:0]  step_reg;
  logic [7:0]  sp_reg;
  logic [15:0] pc_reg;
  logic [7:0]  acc_reg;
  logic [7:0]  idx_reg;
  logic [7:0]  ccr_reg;
  logic [4:0]  vec_reg;
  logic        rd_pend_reg;
  logic        start_irq;
  logic        start_swi;
  logic        start_rti;

  assign start_swi = (state_reg == ST_IDLE) & i_swi_exec;
  assign start_irq = (state_reg == ST_IDLE) & i_insn_boundary & hw_req & ~i_swi_exec; // [RULE_15]
  assign start_rti = (state_reg == ST_IDLE) & i_rti_exec & ~i_swi_exec & ~start_irq;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
      step_reg  <= 3'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          step_reg <= 3'h0;
          if (start_swi | start_irq) begin
            state_reg <= ST_PUSH;
          end else if (start_rti) begin
            state_reg <= ST_POP;
          end
        end
        ST_PUSH: begin
          step_reg <= step_reg + 3'h1;
          if (step_reg == PUSH_BYTES - 3'h1) begin
            state_reg <= ST_VEC;
            step_reg  <= 3'h0;
          end
        end
        ST_VEC: begin
          step_reg <= step_reg + 3'h1;
          // read data land two edges after the strobe, so wait for both bytes
          if (step_reg == 3'h3) begin
            state_reg <= ST_FILL;
            step_reg  <= 3'h0;
          end
        end
        ST_POP: begin
          step_reg <= step_reg + 3'h1;
          if (step_reg == PUSH_BYTES + 3'h1) begin
            state_reg <= ST_FILL;
            step_reg  <= 3'h0;
          end
        end
        ST_FILL: begin
          step_reg <= step_reg + 3'h1;
          if (step_reg == FILL_BYTES + 3'h1) begin
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // snapshot of core registers; the index high byte is left to software
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pc_reg  <= 16'h0000;
      acc_reg <= 8'h00;
      idx_reg <= 8'h00;
      ccr_reg <= 8'h00;
      vec_reg <= VEC_NONE;
    end else if (start_swi | start_irq | start_rti) begin
      pc_reg  <= i_next_pc; // [RULE_03]
      acc_reg <= i_acc;
      idx_reg <= i_idx_low; // [RULE_05]
      ccr_reg <= i_ccr;
      vec_reg <= start_swi ? VEC_SWI : top_vec; // [RULE_15]
    end else if (rd_pend_reg && state_reg == ST_VEC) begin
      if (step_reg == 3'h2) begin
        pc_reg[15:8] <= i_mem_rdata; // [RULE_13]
      end else begin
        pc_reg[7:0]  <= i_mem_rdata;
      end
    end else if (rd_pend_reg && state_reg == ST_POP) begin
      case (step_reg)
        3'h2: ccr_reg      <= i_mem_rdata; // [RULE_04]
        3'h3: acc_reg      <= i_mem_rdata;
        3'h4: idx_reg      <= i_mem_rdata;
        3'h5: pc_reg[15:8] <= i_mem_rdata;
        default: pc_reg[7:0] <= i_mem_rdata;
      endcase
    end
  end

  // stack pointer walks down on push, up before each pop
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sp_reg <= SP_RESET;
    end else if (start_swi | start_irq | start_rti) begin
      sp_reg <= i_sp;
    end else if (state_reg == ST_PUSH) begin
      sp_reg <= sp_reg - 8'h01; // [RULE_02]
    end else if (state_reg == ST_POP && step_reg < PUSH_BYTES) begin
      sp_reg <= sp_reg + 8'h01;
    end
  end

  // memory port: write data and addresses are registered
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_mem_addr  <= 16'h0000;
      o_mem_wdata <= 8'h00;
      o_mem_wr    <= 1'b0;
      o_mem_rd    <= 1'b0;
      rd_pend_reg <= 1'b0;
    end else begin
      o_mem_wr    <= 1'b0;
      o_mem_rd    <= 1'b0;
      rd_pend_reg <= o_mem_rd;
      case (state_reg)
        ST_PUSH: begin
          o_mem_wr   <= 1'b1;
          o_mem_addr <= {8'h00, sp_reg}; // [RULE_02]
          case (step_reg)
            3'h0: o_mem_wdata <= pc_reg[7:0]; // [RULE_01]
            3'h1: o_mem_wdata <= pc_reg[15:8];
            3'h2: o_mem_wdata <= idx_reg;
            3'h3: o_mem_wdata <= acc_reg;
            default: o_mem_wdata <= ccr_reg;
          endcase
        end
        ST_VEC: begin
          o_mem_rd   <= (step_reg < 3'h2);
          o_mem_addr <= vector_addr(vec_reg) + {15'h0000, step_reg[0]}; // [RULE_13]
        end
        ST_POP: begin
          o_mem_rd   <= (step_reg < PUSH_BYTES);
          o_mem_addr <= {8'h00, sp_reg + 8'h01}; // [RULE_04]
        end
        ST_FILL: begin
          o_mem_rd   <= (step_reg < FILL_BYTES); // [RULE_04]
          o_mem_addr <= pc_reg + {13'h0000, step_reg};
        end
        default: begin
          o_mem_addr <= o_mem_addr;
        end
      endcase
    end
  end

  // results toward the core
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_busy        <= 1'b0;
      o_set_mask    <= 1'b0;
      o_fill_byte   <= 8'h00;
      o_fill_valid  <= 1'b0;
      o_done        <= 1'b0;
      o_new_pc      <= 16'h0000;
      o_new_sp      <= SP_RESET;
      o_new_acc     <= 8'h00;
      o_new_idx_low <= 8'h00;
      o_new_ccr     <= 8'h00;
    end else begin
      o_busy       <= (state_reg != ST_IDLE) | start_swi | start_irq | start_rti;
      o_set_mask   <= (state_reg == ST_PUSH) && (step_reg == PUSH_BYTES - 3'h1); // [RULE_15]
      o_fill_valid <= rd_pend_reg && (state_reg == ST_FILL);
      o_fill_byte  <= i_mem_rdata;
      o_done       <= (state_reg == ST_DONE);
      if (state_reg == ST_DONE) begin
        o_new_pc      <= pc_reg;
        o_new_sp      <= sp_reg;
        o_new_acc     <= acc_reg;
        o_new_idx_low <= idx_reg;
        o_new_ccr     <= ccr_reg;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register read port, data one cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        REG_PIN_CTRL: o_reg_rdata <= (pin_ctrl_reg & 8'h73) | {4'h0, pin_flag_reg, 3'h0};
        REG_PENDING:  o_reg_rdata <= {3'h0, top_vec};
        REG_SEQ_STAT: o_reg_rdata <= {5'h00, state_reg};
        default:      o_reg_rdata <= 8'h00;
      endcase
    end else begin
      o_reg_rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// >>> testbench/ipv_irq_ctrl_props.sv
`timescale 1ns/1ns
`default_nettype none
module ipv_irq_ctrl_chk (
  // watched ports
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_stop_mode,
  input wire logic        i_mask_bit,
  input wire logic        o_stop_wake,
  input wire logic        o_pull_up_en,
  input wire logic        o_pull_down_en,
  input wire logic [15:0] o_mem_addr,
  input wire logic        o_mem_wr,
  input wire logic        o_mem_rd,
  input wire logic        o_irq_req,
  input wire logic        o_busy,
  input wire logic        o_set_mask,
  input wire logic        o_fill_valid,
  input wire logic        o_done
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////
  a_push_five_bytes:
    assert property ($rose(o_mem_wr) |-> o_mem_wr [*5] ##1 !o_mem_wr)
    else $error("push burst length wrong");
  a_push_downward:
    assert property (o_mem_wr && $past(o_mem_wr) |-> o_mem_addr == $past(o_mem_addr) - 16'h1)
    else $error("push address not falling by one");
  // vector pair, pop and refill bursts all climb one byte at a time
  a_read_ascending:
    assert property (o_mem_rd && $past(o_mem_rd) |-> o_mem_addr == $past(o_mem_addr) + 16'h1)
    else $error("read burst address not rising by one");
  a_fill_after_read:
    assert property (o_fill_valid |-> $past(o_mem_rd, 2))
    else $error("refill byte without a read");
  a_done_bounded:
    assert property ($rose(o_busy) |-> ##[8:24] o_done)
    else $error("sequence did not finish in time");
  a_done_in_busy:
    assert property (o_done |-> o_busy)
    else $error("done outside busy");
  a_mask_on_last:
    assert property (o_set_mask |-> o_mem_wr ##1 !o_mem_wr)
    else $error("mask set away from last push");
  a_req_unmasked:
    assert property (o_irq_req |-> !$past(i_mask_bit))
    else $error("request while masked");
  a_pull_exclusive:
    assert property (!(o_pull_up_en && o_pull_down_en))
    else $error("both pulls on");
  a_wake_in_stop:
    assert property (o_stop_wake |-> i_stop_mode)
    else $error("wake outside stop");
  c_entry: cover property (o_set_mask);
  c_fill: cover property (o_fill_valid);
  c_wake: cover property (o_stop_wake);
endmodule
bind ipv_irq_ctrl ipv_irq_ctrl_chk u_chk (
  .i_clk, .i_rst, .i_stop_mode, .i_mask_bit, .o_stop_wake, .o_pull_up_en, .o_pull_down_en,
  .o_mem_addr, .o_mem_wr, .o_mem_rd, .o_irq_req, .o_busy, .o_set_mask, .o_fill_valid, .o_done
);
`default_nettype wire

// >>> testbench/ipv_core_mem.sv
`timescale 1ns/1ns
`default_nettype none
module ipv_core_mem (
  // memory port of the core
  input  wire logic        i_clk,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata
);
  logic [7:0]  mem [0:65535];
  logic [23:0] wlog [$];
  logic [15:0] rlog [$];
  initial o_rdata = 8'h5A;
  // data stand one cycle only; late sampling sees a flipped byte
  always @(posedge i_clk) begin
    if (i_rd) begin
      o_rdata <= mem[i_addr];
      rlog.push_back(i_addr);
    end else begin
      o_rdata <= ~o_rdata;
    end
    if (i_wr) begin
      mem[i_addr] <= i_wdata;
      wlog.push_back({i_addr, i_wdata});
    end
  end
endmodule
`default_nettype wire

// >>> testbench/test_irq_pin_and_vector_control.sv
`timescale 1ns/1ns
`default_nettype none
module test_irq_pin_and_vector_control;
  import ipv_pkg::*;
  logic        i_clk = 1'b0, i_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_pin = 1'b1;
  logic        i_stop_mode = 1'b0, i_insn_boundary = 1'b0, i_mask_bit = 1'b1;
  logic        i_swi_exec = 1'b0, i_rti_exec = 1'b0;
  logic [7:0]  i_reg_addr = 8'h00, i_reg_wdata = 8'h00, i_sp = 8'h00, i_acc = 8'h00;
  logic [7:0]  i_idx_low = 8'h00, i_ccr = 8'h00;
  logic [15:0] i_next_pc = 16'h0000;
  logic [31:0] i_periph_flag = 32'h0, i_periph_enable = 32'h0, f, e;
  logic        o_stop_wake, o_pull_up_en, o_pull_down_en, o_pin_level, o_mem_wr, o_mem_rd;
  logic        o_irq_req, o_busy, o_set_mask, o_fill_valid, o_done;
  logic [7:0]  o_reg_rdata, o_mem_wdata, i_mem_rdata, o_fill_byte, o_new_sp, o_new_acc;
  logic [7:0]  o_new_idx_low, o_new_ccr, fills [$];
  logic [15:0] o_mem_addr, o_new_pc;
  int          seed = 32'h9AEF4A25, miscompares = 0, compares = 0;
  int          srcs [13] = '{3, 4, 5, 7, 9, 10, 11, 19, 20, 21, 25, 26, 29};
  ipv_irq_ctrl dut (
    .i_clk, .i_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_pin,
    .i_stop_mode, .o_stop_wake, .o_pull_up_en, .o_pull_down_en, .o_pin_level, .i_periph_flag,
    .i_periph_enable, .i_insn_boundary, .i_mask_bit, .i_swi_exec, .i_rti_exec, .i_next_pc,
    .i_sp, .i_acc, .i_idx_low, .i_ccr, .o_mem_addr, .o_mem_wdata, .o_mem_wr, .o_mem_rd,
    .i_mem_rdata, .o_irq_req, .o_busy, .o_set_mask, .o_fill_byte, .o_fill_valid, .o_done,
    .o_new_pc, .o_new_sp, .o_new_acc, .o_new_idx_low, .o_new_ccr
  );
  ipv_core_mem mdl (
    .i_clk, .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_wr(o_mem_wr), .i_rd(o_mem_rd),
    .o_rdata(i_mem_rdata)
  );
  always #2 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_fill_valid) fills.push_back(o_fill_byte);
  ////////////////////////////////////////
  task automatic cmp_core(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1;
    cmp_core(24'(o_reg_rdata), 24'(exp));
  endtask
  task automatic set_pin(input logic p, input logic s);
    @(posedge i_clk);
    i_pin <= p;
    i_stop_mode <= s;
    repeat (3) @(posedge i_clk);
    #1;
  endtask
  // highest priority is the lowest wired vector number; 31 means none
  function automatic logic [7:0] exp_pend(input logic [31:0] fl, input logic [31:0] en);
    for (int i = 0; i < 13; i++)
      if (fl[srcs[i]] && en[srcs[i]]) return 8'(srcs[i]);
    return 8'h1F;
  endfunction
  task automatic wait_done();
    int k;
    fills.delete();
    mdl.wlog.delete();
    mdl.rlog.delete();
    @(posedge i_clk);
    i_swi_exec <= 1'b0;
    i_rti_exec <= 1'b0;
    i_insn_boundary <= 1'b0;
    i_periph_flag <= 32'h0;
    for (k = 0; k < 60; k++) begin
      @(posedge i_clk);
      #1;
      if (o_done === 1'b1) break;
    end
    cmp_core(24'(k < 60), 24'h1);
  endtask
  task automatic run_seq(input int vec);
    logic [15:0] pc, isr, va;
    logic [7:0]  sp, xl, acc, condition_code_reg;
    pc = {2'b01, 14'($random(seed))};
    isr = {2'b10, 14'($random(seed))};
    sp = 8'hF0;
    {xl, acc, condition_code_reg} = 24'($random(seed));
    va = 16'hFFFE - 16'(2 * vec);
    mdl.mem[va] = isr[15:8];
    mdl.mem[va + 16'h1] = isr[7:0];
    for (int i = 0; i < 3; i++) begin
      mdl.mem[isr + 16'(i)] = 8'($random(seed));
      mdl.mem[pc + 16'(i)] = 8'($random(seed));
    end
    @(posedge i_clk);
    {i_next_pc, i_sp, i_acc, i_idx_low, i_ccr} <= {pc, sp, acc, xl, condition_code_reg};
    i_periph_flag <= 32'h1 << vec;
    i_periph_enable <= 32'h1 << vec;
    i_mask_bit <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_swi_exec <= (vec == 1);
    i_insn_boundary <= (vec != 1);
    wait_done();
    cmp_core(24'(o_new_sp), 24'(sp - 8'h05));
    for (int i = 0; i < 5; i++)
      cmp_core(mdl.wlog[i], {8'h00, sp - 8'(i), 8'(({condition_code_reg, acc, xl, pc} >> (8 * i)))});
    cmp_core(24'(mdl.rlog[0]), 24'(va));
    cmp_core(24'(mdl.rlog[1]), 24'(va + 16'h1));
    for (int i = 0; i < 3; i++) begin
      cmp_core(24'(mdl.rlog[2 + i]), 24'(isr + 16'(i)));
      cmp_core(24'(fills[i]), 24'(mdl.mem[isr + 16'(i)]));
    end
    @(posedge i_clk);
    i_sp <= sp - 8'h05;
    {i_next_pc, i_acc, i_idx_low, i_ccr} <= ~{pc, acc, xl, condition_code_reg};
    i_rti_exec <= 1'b1;
    wait_done();
    cmp_core({o_new_pc, o_new_sp}, {pc, sp});
    cmp_core({o_new_idx_low, o_new_acc, o_new_ccr}, {xl, acc, condition_code_reg});
    cmp_core(24'(mdl.wlog.size()), 24'h0);
    for (int i = 0; i < 5; i++)
      cmp_core(24'(mdl.rlog[i]), 24'(sp - 8'h04 + 8'(i)));
    for (int i = 0; i < 3; i++) begin
      cmp_core(24'(mdl.rlog[5 + i]), 24'(pc + 16'(i)));
      cmp_core(24'(fills[i]), 24'(mdl.mem[pc + 16'(i)]));
    end
  endtask
  ////////////////////////////////////////
  initial begin
    #20000;
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    chk_rd(REG_PIN_CTRL, PIN_CTRL_RESET);
    cmp_core(24'(o_new_sp), 24'(SP_RESET));
    reg_wr(REG_PIN_CTRL, 8'h10);
    chk_rd(REG_PIN_CTRL, 8'h18);
    cmp_core(24'({o_pull_up_en, o_pull_down_en}), 24'h2);
    reg_wr(REG_PIN_CTRL, 8'h14);
    chk_rd(REG_PIN_CTRL, 8'h10);
    set_pin(1'b0, 1'b0);
    cmp_core(24'(o_pin_level), 24'h0);
    chk_rd(REG_PIN_CTRL, 8'h18);
    reg_wr(REG_PIN_CTRL, 8'h14);
    chk_rd(REG_PIN_CTRL, 8'h10);
    reg_wr(REG_PIN_CTRL, 8'h15);
    chk_rd(REG_PIN_CTRL, 8'h19);
    set_pin(1'b1, 1'b0);
    reg_wr(REG_PIN_CTRL, 8'h15);
    chk_rd(REG_PIN_CTRL, 8'h11);
    set_pin(1'b0, 1'b1);
    cmp_core(24'(o_stop_wake), 24'h1);
    set_pin(1'b1, 1'b1);
    cmp_core(24'(o_stop_wake), 24'h0);
    reg_wr(REG_PIN_CTRL, 8'h34);
    set_pin(1'b1, 1'b0);
    cmp_core(24'({o_pull_up_en, o_pull_down_en}), 24'h1);
    reg_wr(REG_PIN_CTRL, 8'h74);
    set_pin(1'b1, 1'b0);
    cmp_core(24'({o_pull_up_en, o_pull_down_en}), 24'h0);
    reg_wr(REG_PIN_CTRL, 8'h04);
    set_pin(1'b0, 1'b0);
    set_pin(1'b1, 1'b0);
    chk_rd(REG_PIN_CTRL, 8'h00);
    chk_rd(8'h40, 8'h00);
    reg_wr(REG_PIN_CTRL, 8'h10);
    reg_wr(REG_PIN_CTRL, 8'h14);
    repeat (6) @(posedge i_clk);
    reg_wr(REG_PIN_CTRL, 8'h12);
    chk_rd(REG_PENDING, 8'h1F);
    set_pin(1'b0, 1'b0);
    chk_rd(REG_PENDING, VEC_PIN);
    set_pin(1'b1, 1'b0);
    reg_wr(REG_PIN_CTRL, 8'h04);
    for (int n = 0; n < 40; n++) begin
      f = (n == 0) ? ~PERIPH_VALID : $random(seed) & $random(seed);
      e = (n == 0) ? 32'hFFFFFFFF : $random(seed) & $random(seed);
      @(posedge i_clk);
      i_periph_flag <= f;
      i_periph_enable <= e;
      i_mask_bit <= n[0];
      chk_rd(REG_PENDING, exp_pend(f, e));
      cmp_core(24'(o_irq_req), 24'(exp_pend(f, e) != 8'h1F && !n[0]));
    end
    foreach (srcs[i])
      run_seq(srcs[i]);
    run_seq(1);
    print_verdict();
  end
endmodule
`default_nettype wire
